// ---- logic/mfe_ctrl_pkg.sv ----
// Shared constants for the modem front-end reset, mode and test control
package mfe_ctrl_pkg;

  // ****************************************
  // Register offsets on the serial port
  // ****************************************
  localparam logic [6:0] ADR_RESET = 7'h00;
  localparam logic [6:0] ADR_LOWPOW = 7'h07;
  localparam logic [6:0] ADR_TEST = 7'h0D;
  localparam logic [6:0] ADR_BIAS = 7'h13;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SOFT_RST_BIT = 5;
  localparam int LOWPOW_BIT = 4;
  localparam int CONT_GAIN_HI = 7;
  localparam int CONT_GAIN_LO = 5;
  localparam int SWCAP_GAIN_HI = 4;
  localparam int SWCAP_GAIN_LO = 3;
  localparam int ADCB_HI = 2;
  localparam int ADCB_LO = 0;
  localparam int TEST_ALB_BIT = 7;
  localparam int TEST_DLB_BIT = 6;
  localparam int TEST_TRI_BIT = 5;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] BIAS_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [2:0] ADC_LOWPOW_CODE = 3'h3;
  // Strap-dependent defaults of the low-power register, one per strap pair
  localparam logic [7:0] LP_DEF_HALF_C0 = 8'h00;
  localparam logic [7:0] LP_DEF_HALF_C1 = 8'h00;
  localparam logic [7:0] LP_DEF_FULL_C0 = 8'h00;
  localparam logic [7:0] LP_DEF_FULL_C1 = 8'h00;

  // ****************************************
  // Serial frame: 1 direction bit, 7 address bits, 8 data bits
  // ****************************************
  localparam logic [4:0] SPI_HDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRM_LAST = 5'h0F;

  // Default of the low-power register picked from the two straps
  function automatic logic [7:0] lp_default(input logic duplex, input logic cfg);
    case ({duplex, cfg})
      2'b00: lp_default = LP_DEF_HALF_C0;
      2'b01: lp_default = LP_DEF_HALF_C1;
      2'b10: lp_default = LP_DEF_FULL_C0;
      default: lp_default = LP_DEF_FULL_C1;
    endcase
  endfunction

endpackage

// ---- logic/spi_reg_port.sv ----
// Serial register port: frame capture, write strobe and read shift-out
`timescale 1ns/1ps
module spi_reg_port
  import mfe_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serial_port_enable_pin,
  input wire logic spi_clk,
  input wire logic spi_din,
  input wire logic [7:0] rd_data,
  output logic [6:0] addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic spi_dout,
  output logic spi_dout_oe_n
);

  typedef struct packed {
    logic clk_prev;
    logic [4:0] cnt;
    logic [6:0] sh;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdat;
    logic wr;
    logic ld;
    logic [7:0] osh;
    logic oe_n;
  } port_t;

  port_t st_ff;
  port_t nxt_st;

  // ****************************************
  // Frame engine
  // ****************************************
  // Serial clock is sampled, so it must stay well below half of sys_clk
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.ld = 1'b0;
    nxt_st.clk_prev = spi_clk;
    if (srst) begin
      nxt_st = '0;
      nxt_st.oe_n = 1'b1;
    end else if (serial_port_enable_pin) begin
      nxt_st.cnt = '0;
      nxt_st.oe_n = 1'b1;
    end else begin
      // Rising edge takes a bit
      if (spi_clk && !st_ff.clk_prev) begin
        nxt_st.sh = {st_ff.sh[5:0], spi_din};
        nxt_st.cnt = st_ff.cnt + 5'h01;
        if (st_ff.cnt == SPI_HDR_LAST) begin
          nxt_st.rd = st_ff.sh[6];
          nxt_st.addr = {st_ff.sh[5:0], spi_din};
          nxt_st.ld = st_ff.sh[6];
        end
        if (st_ff.cnt == SPI_FRM_LAST) begin
          nxt_st.wdat = {st_ff.sh[6:0], spi_din};
          nxt_st.wr = !st_ff.rd;
          nxt_st.cnt = '0;
          nxt_st.oe_n = 1'b1;
        end
      end
      // Falling edge moves the next read bit out
      if (!spi_clk && st_ff.clk_prev && !st_ff.oe_n) begin
        nxt_st.osh = {st_ff.osh[6:0], 1'b0};
      end
      if (st_ff.ld) begin
        nxt_st.osh = rd_data;
        nxt_st.oe_n = 1'b0;
      end
    end
  end

  // State register; system reset lives in the frame engine
  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end

  assign addr = st_ff.addr;
  assign wr_data = st_ff.wdat;
  assign wr_stb = st_ff.wr;
  assign spi_dout = st_ff.osh[7];
  assign spi_dout_oe_n = st_ff.oe_n;

  // ****************************************
  // Checks
  // ****************************************
  property p_port_off;
    @(posedge sys_clk) disable iff (srst)
    serial_port_enable_pin |=> !wr_stb && spi_dout_oe_n;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("serial port active while disabled");

endmodule

// ---- logic/mfe_reset_ctrl.sv ----
// Mode straps, resets, receive bias and test-mode control of the front end
// How it works
// - Bias register splits into three bias codes
// - Bias register resets to zero
// - Low-power bit forces converter bias 011
// - Duplex strap picks half or full duplex
// - Both straps choose the low-power register default
// - Serial enable high disables register port
// - Pin or soft reset reloads strap state
// - Calibration after hardware reset only
// - Resets never clear transmit filter data
// - Reset pin low loads defaults at once
// - Calibration starts on reset pin release
// - Analog loop-back feeds converter into transmit
// - Digital loop-back returns transmit port word
// - Three-state bit floats receive port
`timescale 1ns/1ps
module mfe_reset_ctrl
  import mfe_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic duplex_strap,
  input wire logic config_strap,
  input wire logic serial_port_enable_pin,
  input wire logic spi_clk,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe_n,
  input wire logic [9:0] tx_word,
  input wire logic [5:0] tx_port,
  input wire logic [9:0] adc_word,
  input wire logic [5:0] rx_word,
  output logic [9:0] tx_filter_in,
  output logic [5:0] rx_port,
  output logic [5:0] rx_port_oe_n,
  output logic full_duplex,
  output logic calib_start,
  output logic [2:0] continuous_gain_amp_bias,
  output logic [1:0] switched_cap_gain_amp_bias,
  output logic [2:0] adc_bias
);

  typedef struct packed {
    logic [7:0] lp;
    logic [7:0] test;
    logic [7:0] bias;
    logic fdx;
    logic pin_prev;
    logic calib;
    logic [2:0] cont_bias;
    logic [1:0] swcap_bias;
    logic [2:0] adcb;
    logic [9:0] txf;
    logic [5:0] rx;
    logic [5:0] rx_oe_n;
  } ctl_t;

  ctl_t st_ff;
  ctl_t nxt_st;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic wr_stb;
  logic [7:0] rd_data;
  logic soft_rst;
  logic load_def;

  // ****************************************
  // Serial register port
  // ****************************************
  spi_reg_port spi_reg_port_i (
    .sys_clk(sys_clk),
    .srst(srst),
    .serial_port_enable_pin(serial_port_enable_pin),
    .spi_clk(spi_clk),
    .spi_din(spi_din),
    .rd_data(rd_data),
    .addr(addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .spi_dout(spi_dout),
    .spi_dout_oe_n(spi_dout_oe_n)
  );

  // Read mux; the reset register and unmapped offsets read zero
  always_comb begin
    case (addr)
      ADR_LOWPOW: rd_data = st_ff.lp;
      ADR_TEST: rd_data = st_ff.test;
      ADR_BIAS: rd_data = st_ff.bias;
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Register file and reset sequencing
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    soft_rst = 1'b0;
    nxt_st.pin_prev = reset_pin_n;
    nxt_st.calib = reset_pin_n && !st_ff.pin_prev;
    // Writes are dropped while any reset is active
    if (wr_stb && !srst && reset_pin_n) begin
      case (addr)
        ADR_LOWPOW: nxt_st.lp = wr_data;
        ADR_TEST: nxt_st.test = wr_data;
        ADR_BIAS: nxt_st.bias = wr_data;
        ADR_RESET: soft_rst = wr_data[SOFT_RST_BIT];
        default: soft_rst = 1'b0;
      endcase
    end
    load_def = srst || !reset_pin_n || soft_rst;
    if (load_def) begin
      nxt_st.lp = lp_default(duplex_strap, config_strap);
      nxt_st.test = TEST_RST;
      nxt_st.bias = BIAS_RST;
      nxt_st.fdx = duplex_strap;
    end
    if (srst) begin
      nxt_st.pin_prev = 1'b1;
      nxt_st.calib = 1'b0;
    end
    nxt_st.cont_bias = nxt_st.bias[CONT_GAIN_HI:CONT_GAIN_LO];
    nxt_st.swcap_bias = nxt_st.bias[SWCAP_GAIN_HI:SWCAP_GAIN_LO];
    if (nxt_st.lp[LOWPOW_BIT]) begin
      nxt_st.adcb = ADC_LOWPOW_CODE;
    end else begin
      nxt_st.adcb = nxt_st.bias[ADCB_HI:ADCB_LO];
    end
    nxt_st.txf = st_ff.test[TEST_ALB_BIT] ? adc_word : tx_word;
    nxt_st.rx = st_ff.test[TEST_DLB_BIT] ? tx_port : rx_word;
    nxt_st.rx_oe_n = st_ff.test[TEST_TRI_BIT] ? 6'h3F : 6'h00;
    if (srst) begin
      nxt_st.rx = 6'h00;
      nxt_st.rx_oe_n = 6'h00;
    end
  end

  // Single state register; system reset is folded into the next-state logic
  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs, all taken from the state register
  // ****************************************
  assign tx_filter_in = st_ff.txf;
  assign rx_port = st_ff.rx;
  assign rx_port_oe_n = st_ff.rx_oe_n;
  assign full_duplex = st_ff.fdx;
  assign calib_start = st_ff.calib;
  assign continuous_gain_amp_bias = st_ff.cont_bias;
  assign switched_cap_gain_amp_bias = st_ff.swcap_bias;
  assign adc_bias = st_ff.adcb;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence s_soft_wr;
    wr_stb && reset_pin_n && (addr == ADR_RESET) && wr_data[SOFT_RST_BIT];
  endsequence

  sequence s_pin_release;
    !reset_pin_n ##1 reset_pin_n;
  endsequence

  property p_bias_split;
    !st_ff.lp[LOWPOW_BIT] |->
      {continuous_gain_amp_bias, switched_cap_gain_amp_bias, adc_bias} == st_ff.bias;
  endproperty
  a_bias_split: assert property (p_bias_split)
    else $error("bias fields do not match register");

  property p_bias_reset;
    !reset_pin_n |=> st_ff.bias == BIAS_RST && continuous_gain_amp_bias == 3'h0;
  endproperty
  a_bias_reset: assert property (p_bias_reset)
    else $error("bias not zero after reset");

  property p_lowpow_alias;
    st_ff.lp[LOWPOW_BIT] |-> adc_bias == ADC_LOWPOW_CODE;
  endproperty
  a_lowpow_alias: assert property (p_lowpow_alias)
    else $error("low-power bit did not force converter code");

  property p_duplex_strap;
    !reset_pin_n |=> full_duplex == $past(duplex_strap);
  endproperty
  a_duplex_strap: assert property (p_duplex_strap)
    else $error("duplex does not follow strap");

  property p_soft_reset;
    s_soft_wr |=> st_ff.test == TEST_RST && st_ff.bias == BIAS_RST
      && st_ff.lp == lp_default($past(duplex_strap), $past(config_strap));
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not reload defaults");

  property p_soft_no_calib;
    s_soft_wr ##0 $past(reset_pin_n) |=> !calib_start;
  endproperty
  a_soft_no_calib: assert property (p_soft_no_calib)
    else $error("calibration launched by soft reset");

  property p_calib_edge;
    s_pin_release |=> calib_start ##1 !calib_start;
  endproperty
  a_calib_edge: assert property (p_calib_edge)
    else $error("calibration pulse missing after pin release");

  property p_calib_cause;
    calib_start |-> $past(reset_pin_n) && !$past(reset_pin_n, 2);
  endproperty
  a_calib_cause: assert property (p_calib_cause)
    else $error("calibration without pin release");

  property p_analog_lb;
    st_ff.test[TEST_ALB_BIT] |=> tx_filter_in == $past(adc_word);
  endproperty
  a_analog_lb: assert property (p_analog_lb)
    else $error("analog loop-back path wrong");

  property p_digital_lb;
    st_ff.test[TEST_DLB_BIT] |=> rx_port == $past(tx_port);
  endproperty
  a_digital_lb: assert property (p_digital_lb)
    else $error("digital loop-back path wrong");

  property p_rx_float;
    st_ff.test[TEST_TRI_BIT] |=> rx_port_oe_n == 6'h3F;
  endproperty
  a_rx_float: assert property (p_rx_float)
    else $error("receive port not floated");

  property p_test_reset;
    !reset_pin_n |=> st_ff.test == TEST_RST ##1 rx_port_oe_n == 6'h00;
  endproperty
  a_test_reset: assert property (p_test_reset)
    else $error("test modes not cleared by reset");

  // ****************************************
  // Write landing and normal data paths
  // ****************************************
  sequence s_bias_wr;
    wr_stb && reset_pin_n && (addr == ADR_BIAS);
  endsequence

  sequence s_test_wr;
    wr_stb && reset_pin_n && (addr == ADR_TEST);
  endsequence

  property p_bias_write;
    s_bias_wr |=> st_ff.bias == $past(wr_data);
  endproperty
  a_bias_write: assert property (p_bias_write)
    else $error("bias write did not land");

  property p_test_write;
    s_test_wr |=> st_ff.test == $past(wr_data);
  endproperty
  a_test_write: assert property (p_test_write)
    else $error("test write did not land");

  // Pin reset reloads the strap-chosen defaults on the next edge
  property p_pin_defaults;
    !reset_pin_n |=> st_ff.lp == lp_default($past(duplex_strap), $past(config_strap));
  endproperty
  a_pin_defaults: assert property (p_pin_defaults)
    else $error("pin reset did not load strap defaults");

  // Filter feed keeps flowing through any reset
  property p_tx_normal;
    !st_ff.test[TEST_ALB_BIT] |=> tx_filter_in == $past(tx_word);
  endproperty
  a_tx_normal: assert property (p_tx_normal)
    else $error("transmit feed lost its word");

  property p_rx_normal;
    !st_ff.test[TEST_DLB_BIT] |=> rx_port == $past(rx_word);
  endproperty
  a_rx_normal: assert property (p_rx_normal)
    else $error("receive port not fed by receive word");

  property p_rx_driven;
    !st_ff.test[TEST_TRI_BIT] |=> rx_port_oe_n == 6'h00;
  endproperty
  a_rx_driven: assert property (p_rx_driven)
    else $error("receive port floated without test bit");

  // A pin that stays high never launches calibration
  property p_calib_quiet;
    reset_pin_n ##1 reset_pin_n |=> !calib_start;
  endproperty
  a_calib_quiet: assert property (p_calib_quiet)
    else $error("calibration launched without pin release");

endmodule

// ---- verif/serial_host.sv ----
// Serial register host and reset pin driver facing the control block
`timescale 1ns/1ps
module serial_host (
  input wire logic sys_clk,
  input wire logic spi_dout,
  input wire logic spi_dout_oe_n,
  output logic spi_clk,
  output logic spi_din,
  output logic serial_port_enable_pin,
  output logic reset_pin_n
);
  // ****
  // Power-up
  // ****
  // Pin held low at power-up before any traffic
  initial begin
    spi_clk = 1'b0;
    spi_din = 1'b0;
    serial_port_enable_pin = 1'b1;
    reset_pin_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
  end

  // ****
  // Bus tasks
  // ****
  // Reset pin level change on a clock edge
  task automatic pin(input logic v);
    @(posedge sys_clk);
    reset_pin_n <= v;
  endtask

  // One 16-bit frame; bits shifted out after the address are collected
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
                       input logic en, output logic [7:0] q);
    logic [15:0] w;
    w = {rd, a, d};
    q = 8'h00;
    @(posedge sys_clk);
    serial_port_enable_pin <= ~en;
    for (int i = 15; i >= 0; i--) begin
      @(posedge sys_clk);
      spi_din <= w[i];
      // Long phases, the serial clock is only sampled by sys_clk
      repeat (3) @(posedge sys_clk);
      spi_clk <= 1'b1;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      if (i >= 1 && i <= 8) begin
        q[i-1] = spi_dout_oe_n ? 1'bx : spi_dout;
      end
      @(posedge sys_clk);
      spi_clk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    serial_port_enable_pin <= 1'b1;
    // Released data line must not keep its last value
    spi_din <= ~spi_din;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// ---- verif/reset_mode_test_control_test.sv ----
// Self-checking bench for the reset, mode, bias and test control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module reset_mode_test_control_test;
  import mfe_ctrl_pkg::*;
  logic sys_clk = 1'b0;
  logic srst, reset_pin_n, duplex_strap, config_strap, serial_port_enable_pin, spi_clk, spi_din;
  logic spi_dout, spi_dout_oe_n, full_duplex, calib_start;
  logic [9:0] tx_word, adc_word, tx_filter_in;
  logic [5:0] tx_port, rx_word, rx_port, rx_port_oe_n;
  logic [2:0] cg, ab;
  logic [1:0] sc;
  logic [7:0] bias_o, q;
  int n_fail = 0;
  int num_checks = 0;
  int n_cal = 0;
  int c0;
  assign bias_o = {cg, sc, ab};

  // ****
  // Clock and instances
  // ****
  // Free-running 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  mfe_reset_ctrl mfe_reset_ctrl_i (.sys_clk(sys_clk), .srst(srst),
    .reset_pin_n(reset_pin_n), .duplex_strap(duplex_strap), .config_strap(config_strap),
    .serial_port_enable_pin(serial_port_enable_pin), .spi_clk(spi_clk), .spi_din(spi_din),
    .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n), .tx_word(tx_word),
    .tx_port(tx_port), .adc_word(adc_word), .rx_word(rx_word),
    .tx_filter_in(tx_filter_in), .rx_port(rx_port), .rx_port_oe_n(rx_port_oe_n),
    .full_duplex(full_duplex), .calib_start(calib_start),
    .continuous_gain_amp_bias(cg), .switched_cap_gain_amp_bias(sc), .adc_bias(ab));

  serial_host serial_host_i (.sys_clk(sys_clk), .spi_dout(spi_dout),
    .spi_dout_oe_n(spi_dout_oe_n), .spi_clk(spi_clk), .spi_din(spi_din),
    .serial_port_enable_pin(serial_port_enable_pin), .reset_pin_n(reset_pin_n));

  // Calibration launches counted, one per pulse
  always @(posedge sys_clk) begin
    if (calib_start === 1'b1) n_cal <= n_cal + 1;
  end

  // ****
  // Tasks
  // ****
  function automatic logic [7:0] exp_lp(input logic dup, input logic cfg);
    exp_lp = dup ? (cfg ? LP_DEF_FULL_C1 : LP_DEF_FULL_C0)
                 : (cfg ? LP_DEF_HALF_C1 : LP_DEF_HALF_C0);
  endfunction

  // Settle on a falling edge so outputs are stable
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    serial_host_i.frame(1'b0, a, d, 1'b1, r);
    tick(2);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    serial_host_i.frame(1'b1, a, 8'h00, 1'b1, r);
    `CHK("rdata", e, r)
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    final_report;
  end

  // ****
  // Main sequence
  // ****
  initial begin
    srst = 1'b1;
    duplex_strap = 1'b0;
    config_strap = 1'b0;
    tx_word = 10'h155;
    tx_port = 6'h2A;
    adc_word = 10'h2C3;
    rx_word = 6'h15;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    tick(30);
    `CHK("bias", BIAS_RST, bias_o)
    `CHK("oe", 6'h00, rx_port_oe_n)
    `CHK("dup", 1'b0, full_duplex)
    rd(ADR_TEST, TEST_RST);
    wr(ADR_BIAS, 8'hB5);
    `CHK("bias", 8'hB5, bias_o)
    rd(ADR_BIAS, 8'hB5);
    rd(7'h21, 8'h00);
    wr(ADR_LOWPOW, 8'h10);
    `CHK("adcb", ADC_LOWPOW_CODE, ab)
    rd(ADR_LOWPOW, 8'h10);
    wr(ADR_TEST, 8'h80);
    `CHK("txf", adc_word, tx_filter_in)
    wr(ADR_TEST, 8'h40);
    `CHK("rxp", tx_port, rx_port)
    @(posedge sys_clk);
    tx_port <= 6'h0F;
    tick(3);
    `CHK("rxp", 6'h0F, rx_port)
    wr(ADR_TEST, 8'h20);
    `CHK("oe", 6'h3F, rx_port_oe_n)
    wr(ADR_TEST, 8'h00);
    `CHK("rxp", rx_word, rx_port)
    `CHK("txf", tx_word, tx_filter_in)
    // Soft reset clears registers but must not calibrate
    c0 = n_cal;
    wr(ADR_TEST, 8'h20);
    wr(ADR_RESET, 8'h20);
    `CHK("bias", 8'h00, bias_o)
    `CHK("oe", 6'h00, rx_port_oe_n)
    rd(ADR_LOWPOW, exp_lp(1'b0, 1'b0));
    `CHK("cal", c0, n_cal)
    // Pin reset with both straps high
    wr(ADR_BIAS, 8'hFF);
    @(posedge sys_clk);
    duplex_strap <= 1'b1;
    config_strap <= 1'b1;
    tx_word <= 10'h0AA;
    c0 = n_cal;
    serial_host_i.pin(1'b0);
    tick(13);
    `CHK("bias", 8'h00, bias_o)
    `CHK("cal", c0, n_cal)
    `CHK("txf", 10'h0AA, tx_filter_in)
    serial_host_i.pin(1'b1);
    tick(5);
    `CHK("cal", c0 + 1, n_cal)
    `CHK("dup", 1'b1, full_duplex)
    rd(ADR_LOWPOW, exp_lp(1'b1, 1'b1));
    // Analog loop-back and three-state once more, now in full duplex
    wr(ADR_TEST, 8'hA0);
    `CHK("txf", adc_word, tx_filter_in)
    `CHK("oe", 6'h3F, rx_port_oe_n)
    // Port disabled: frame clocked with enable held high
    serial_host_i.frame(1'b0, ADR_BIAS, 8'h5A, 1'b0, q);
    tick(2);
    `CHK("bias", 8'h00, bias_o)
    final_report;
  end
endmodule
